// *** sirq_slave.sv ***
// Purpose: Device end: reports IRQ levels, with software forcing.
// Assumes: irqLevel comes from logic on clk_sys; line is synchronous.
// Notes:   Registers reached over APB at four times their index.
`timescale 1ns/1ps
module sirq_slave
    import sirq_pkg::*;
(
    // System
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Interrupt levels, low means asserted
    input  wire logic [15:1] irqLevel,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial IRQ line
    sirq_if.dev              link
);

    logic [7:0]  forceLo_ff;
    logic [7:0]  forceHi_ff;
    logic        fwdEn_ff;
    logic [31:0] prdata_ff;
    sirq_mode_e  mode_ff;
    logic        active_ff;
    logic        prevLine_ff;
    logic [1:0]  lowRun_ff;
    logic [1:0]  phase_ff;
    logic [4:0]  frame_ff;
    logic [15:1] sent_ff;
    logic        selfStart_ff;
    logic        driveEn_ff;
    logic        driveVal_ff;

    logic        wrEn;
    logic        hit;
    logic        line;
    logic        rise;
    logic [15:1] forceVec;
    logic [15:1] effLevel;
    logic [16:0] effPad;
    logic [4:0]  nxtFrame;
    logic        sampleNext;
    logic        pending;
    logic        startNow;
    logic        stopNow;

    //--------------------------------------------------------------
    // APB slave
    //--------------------------------------------------------------
    assign wrEn    = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign prdata  = prdata_ff;
    assign pslverr = psel & penable & ~hit;

    always_comb begin
        if (paddr == DEV_ADDR_FORCE_LO) begin
            hit = 1'b1;
        end else if (paddr == DEV_ADDR_FORCE_HI) begin
            hit = 1'b1;
        end else if (paddr == DEV_ADDR_STATUS) begin
            hit = 1'b1;
        end else if (paddr == DEV_ADDR_CFG) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // Read data captured in setup so it comes from a flop
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata_ff <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_ff <= 32'h00000000;
            if (paddr == DEV_ADDR_FORCE_LO) begin
                prdata_ff[7:0] <= forceLo_ff;
            end else if (paddr == DEV_ADDR_FORCE_HI) begin
                prdata_ff[7:0] <= forceHi_ff;
            end else if (paddr == DEV_ADDR_STATUS) begin
                prdata_ff[15:1] <= sent_ff;
                prdata_ff[16]   <= active_ff;
                prdata_ff[17]   <= mode_ff;
            end else if (paddr == DEV_ADDR_CFG) begin
                prdata_ff[CFG_FWD_BIT] <= fwdEn_ff;
            end
        end
    end

    // only software writes these
    // Forcing and enable registers; no hardware path alters them
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            forceLo_ff <= FORCE_RST;
            forceHi_ff <= FORCE_RST;
            fwdEn_ff   <= 1'b0;
        end else if (wrEn) begin
            if (paddr == DEV_ADDR_FORCE_LO) begin
                forceLo_ff <= pwdata[7:0];
            end else if (paddr == DEV_ADDR_FORCE_HI) begin
                forceHi_ff <= pwdata[7:0];
            end else if (paddr == DEV_ADDR_CFG) begin
                fwdEn_ff <= pwdata[CFG_FWD_BIT];
            end
        end
    end

    //--------------------------------------------------------------
    // Effective levels
    //--------------------------------------------------------------
    // bit 0 of low group unused
    assign forceVec = {forceHi_ff, forceLo_ff[7:1]};

    assign effLevel = irqLevel & ~({15{fwdEn_ff}} & ~forceVec);
    // Index is the frame number: frames 0 and 1 carry no IRQ
    assign effPad   = {effLevel, 2'b11};

    assign pending = |(effLevel ^ sent_ff);

    //--------------------------------------------------------------
    // Line tracking
    //--------------------------------------------------------------
    // sampled on rising edge
    assign line     = link.lineLevel;
    assign rise     = line & ~prevLine_ff;
    assign stopNow  = active_ff & rise & (lowRun_ff >= STOP_LOW_QUIET);
    assign nxtFrame = frame_ff + 5'h01;
    assign sampleNext = active_ff & (phase_ff == PH_TURN) &
                        (nxtFrame >= FRAME_IRQ_LO) &
                        (nxtFrame <= FRAME_LAST);
    assign startNow = ~active_ff & ~rise & line & ~selfStart_ff &
                      (mode_ff == SIRQ_QUIET) & pending;

    // Low-run length, saturating, read at each rising edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prevLine_ff <= 1'b1;
            lowRun_ff   <= 2'h0;
        end else begin
            prevLine_ff <= line;
            if (line) begin
                lowRun_ff <= 2'h0;
            end else if (lowRun_ff != LOW_RUN_MAX) begin
                lowRun_ff <= lowRun_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_ff <= SIRQ_CONT;
        end else if (stopNow) begin
            mode_ff <= (lowRun_ff == STOP_LOW_QUIET) ? SIRQ_QUIET :
                                                       SIRQ_CONT;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            active_ff <= 1'b0;
            phase_ff  <= PH_TURN;
            frame_ff  <= 5'h00;
        end else if (~active_ff & rise) begin
            active_ff <= 1'b1;
            phase_ff  <= PH_TURN;
            frame_ff  <= 5'h00;
        end else if (stopNow) begin
            active_ff <= 1'b0;
        end else if (active_ff) begin
            phase_ff <= (phase_ff == PH_TURN) ? PH_SAMP :
                        phase_ff + 2'h1;
            if (phase_ff == PH_TURN && frame_ff != FRAME_MAX) begin
                frame_ff <= nxtFrame;
            end
        end
    end

    // One own start per idle period; cleared once a cycle begins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            selfStart_ff <= 1'b0;
        end else if (active_ff) begin
            selfStart_ff <= 1'b0;
        end else if (startNow) begin
            selfStart_ff <= 1'b1;
        end
    end

    // Level reported per IRQ, kept to detect later changes
    for (genvar i = 1; i < 16; i++) begin : g_sent
        always_ff @(posedge clk_sys) begin
            if (reset) begin
                sent_ff[i] <= 1'b1;
            end else if (sampleNext && nxtFrame == 5'(i + 1)) begin
                sent_ff[i] <= effLevel[i];
            end
        end
    end

    //--------------------------------------------------------------
    // Line driver
    //--------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            driveEn_ff  <= 1'b0;
            driveVal_ff <= 1'b1;
        end else if (sampleNext) begin
            driveEn_ff  <= ~effPad[nxtFrame];
            driveVal_ff <= 1'b0;
        end else if (active_ff && phase_ff == PH_SAMP &&
                     driveEn_ff && !driveVal_ff) begin
            driveEn_ff  <= 1'b1;
            driveVal_ff <= 1'b1;
        end else if (startNow) begin
            driveEn_ff  <= 1'b1;
            driveVal_ff <= 1'b0;
        end else begin
            driveEn_ff  <= 1'b0;
            driveVal_ff <= 1'b1;
        end
    end

    assign link.devDriveEn  = driveEn_ff & ~reset;
    assign link.devDriveVal = driveVal_ff;

endmodule : sirq_slave

// *** sirq_pkg.sv ***
// Purpose: Shared constants and types for the serial IRQ link ends.
// Assumes: One clock, clk_sys, shared by both ends and the line.
// Notes:   Device registers use index constants; byte address = 4*index.
//
// Operation
// - Quiet start: one low clock, never high
// - No start while a cycle runs
// - Host extends start low, then high, release
// - Quiet mode: level change triggers a start
// - Continuous mode: device never starts cycles
// - Mode changes only at stop frame
// - Reset gives Continuous; host runs first cycle
// - Line released while reset is asserted
// - Frames counted from start rise, three clocks
// - Sample phase: drive low only if low
// - Recovery: drive high after own low
// - Turnaround: driver always released
// - Report levels in every cycle
// - Frame n sample at clock 3n-1
// - Host ends cycle with 2/3 clock stop
// - Stop width two selects Quiet mode
// - Stop width three selects Continuous mode
// - All driving and sampling on rising edge
// - Host levels settle only after full cycle
// - Forcing registers at indices 1B and 1C
// - Config bit 0 gates forcing onto stream
// - Forcing bit zero asserts, one removes
package sirq_pkg;

    //--------------------------------------------------------------
    // Types
    //--------------------------------------------------------------
    typedef enum logic {
        SIRQ_CONT  = 1'b0,
        SIRQ_QUIET = 1'b1
    } sirq_mode_e;

    typedef enum logic [2:0] {
        HS_IDLE       = 3'b000,
        HS_START_LOW  = 3'b001,
        HS_START_HIGH = 3'b010,
        HS_FRAMES     = 3'b011,
        HS_STOP_LOW   = 3'b100,
        HS_STOP_HIGH  = 3'b101
    } sirq_hstate_e;

    //--------------------------------------------------------------
    // Frame timing
    //--------------------------------------------------------------
    localparam logic [1:0] PH_SAMP        = 2'h0;
    localparam logic [1:0] PH_REC         = 2'h1;
    localparam logic [1:0] PH_TURN        = 2'h2;
    localparam logic [4:0] FRAME_IRQ_LO   = 5'h02;
    localparam logic [4:0] FRAME_LAST     = 5'h10;
    localparam logic [4:0] FRAME_MAX      = 5'h1F;
    localparam logic [1:0] STOP_LOW_QUIET = 2'h2;
    localparam logic [1:0] STOP_LOW_CONT  = 2'h3;
    localparam logic [1:0] LOW_RUN_MAX    = 2'h3;
    localparam logic [2:0] START_EXT_MIN  = 3'h3;
    localparam logic [2:0] START_EXT_RST  = 3'h3;

    //--------------------------------------------------------------
    // Device registers (index, byte address is index times four)
    //--------------------------------------------------------------
    localparam logic [9:0]  DEV_IDX_FORCE_LO = 10'h01B;
    localparam logic [9:0]  DEV_IDX_FORCE_HI = 10'h01C;
    localparam logic [9:0]  DEV_IDX_STATUS   = 10'h01D;
    localparam logic [9:0]  DEV_IDX_CFG      = 10'h0F1;
    localparam logic [11:0] DEV_ADDR_FORCE_LO = {DEV_IDX_FORCE_LO, 2'h0};
    localparam logic [11:0] DEV_ADDR_FORCE_HI = {DEV_IDX_FORCE_HI, 2'h0};
    localparam logic [11:0] DEV_ADDR_STATUS   = {DEV_IDX_STATUS, 2'h0};
    localparam logic [11:0] DEV_ADDR_CFG      = {DEV_IDX_CFG, 2'h0};
    localparam logic [7:0]  FORCE_RST         = 8'hFF;
    localparam int          CFG_FWD_BIT       = 0;

    //--------------------------------------------------------------
    // Host controller registers (byte addresses)
    //--------------------------------------------------------------
    localparam logic [11:0] HOST_ADDR_CTRL   = 12'h000;
    localparam logic [11:0] HOST_ADDR_STATUS = 12'h004;
    localparam logic [11:0] HOST_ADDR_LEVELS = 12'h008;
    localparam int          CTRL_GO_BIT      = 0;
    localparam int          CTRL_REPEAT_BIT  = 1;
    localparam int          CTRL_QUIET_BIT   = 2;
    localparam int          CTRL_EXT_LSB     = 4;

endpackage : sirq_pkg

// *** sirq_if.sv ***
// Purpose: One-wire serial IRQ line joining host and device ends.
// Assumes: Line is pulled up; any enabled low driver wins.
// Notes:   The wire level is resolved here from both enables.
`timescale 1ns/1ps
interface sirq_if;

    logic devDriveEn;
    logic devDriveVal;
    logic hostDriveEn;
    logic hostDriveVal;
    logic lineLevel;

    // Wired line with pull-up: low when any enabled driver is low
    assign lineLevel = ~((devDriveEn & ~devDriveVal) |
                         (hostDriveEn & ~hostDriveVal));

    modport dev (
        input  lineLevel,
        output devDriveEn,
        output devDriveVal
    );

    modport host (
        input  lineLevel,
        output hostDriveEn,
        output hostDriveVal
    );

endinterface : sirq_if

// *** sirq_host.sv ***
// Purpose: Host end: runs serial IRQ cycles, collects IRQ levels.
// Assumes: Same clk_sys as the device end; APB slave for software.
// Notes:   Takes over any start pulse begun by a device.
`timescale 1ns/1ps
module sirq_host
    import sirq_pkg::*;
(
    // System
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial IRQ line
    sirq_if.host             link
);

    sirq_hstate_e state_ff;
    logic [2:0]   cnt_ff;
    logic [1:0]   phase_ff;
    logic [4:0]   frame_ff;
    logic         gapOk_ff;
    logic         goReq_ff;
    logic         repeat_ff;
    logic         quietReq_ff;
    logic [2:0]   startExt_ff;
    sirq_mode_e   mode_ff;
    logic [15:1]  rx_ff;
    logic [31:0]  prdata_ff;
    logic         wrEn;
    logic         hit;
    logic         ownStart;

    //--------------------------------------------------------------
    // APB slave
    //--------------------------------------------------------------
    assign wrEn     = psel & penable & pwrite;
    assign pready   = 1'b1;
    assign prdata   = prdata_ff;
    assign pslverr  = psel & penable & ~hit;
    assign ownStart = gapOk_ff & (goReq_ff | repeat_ff);

    // Address decode
    always_comb begin
        if (paddr == HOST_ADDR_CTRL) begin
            hit = 1'b1;
        end else if (paddr == HOST_ADDR_STATUS) begin
            hit = 1'b1;
        end else if (paddr == HOST_ADDR_LEVELS) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata_ff <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_ff <= 32'h00000000;
            if (paddr == HOST_ADDR_CTRL) begin
                prdata_ff[CTRL_GO_BIT]     <= goReq_ff;
                prdata_ff[CTRL_REPEAT_BIT] <= repeat_ff;
                prdata_ff[CTRL_QUIET_BIT]  <= quietReq_ff;
                prdata_ff[CTRL_EXT_LSB+:3] <= startExt_ff;
            end else if (paddr == HOST_ADDR_STATUS) begin
                prdata_ff[0] <= (state_ff != HS_IDLE);
                prdata_ff[1] <= mode_ff;
            end else if (paddr == HOST_ADDR_LEVELS) begin
                prdata_ff[15:1] <= rx_ff;
            end
        end
    end

    // first cycle requested
    // Control register; a write of go wins over the clear at start
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            goReq_ff    <= 1'b1;
            repeat_ff   <= 1'b0;
            quietReq_ff <= 1'b0;
            startExt_ff <= START_EXT_RST;
        end else begin
            if (wrEn & (paddr == HOST_ADDR_CTRL) & pwdata[CTRL_GO_BIT])
            begin
                goReq_ff <= 1'b1;
            end else if (state_ff == HS_IDLE && link.lineLevel &&
                         ownStart) begin
                goReq_ff <= 1'b0;
            end
            if (wrEn & (paddr == HOST_ADDR_CTRL)) begin
                repeat_ff   <= pwdata[CTRL_REPEAT_BIT];
                quietReq_ff <= pwdata[CTRL_QUIET_BIT];
                startExt_ff <= (pwdata[CTRL_EXT_LSB+:3] < START_EXT_MIN) ?
                               START_EXT_MIN : pwdata[CTRL_EXT_LSB+:3];
            end
        end
    end

    //--------------------------------------------------------------
    // Cycle sequencer
    //--------------------------------------------------------------
    // rising edge only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= HS_IDLE;
            cnt_ff   <= 3'h0;
            phase_ff <= PH_TURN;
            frame_ff <= 5'h00;
            gapOk_ff <= 1'b1;
            mode_ff  <= SIRQ_CONT;
        end else begin
            case (state_ff)
                HS_IDLE: begin
                    gapOk_ff <= 1'b1;
                    // take over device start
                    // Count ends at zero so seven extra clocks fit 3 bits
                    if (!link.lineLevel) begin
                        state_ff <= HS_START_LOW;
                        cnt_ff   <= startExt_ff - 3'h1;
                    end else if (ownStart) begin
                        state_ff <= HS_START_LOW;
                        cnt_ff   <= startExt_ff;
                    end
                end
                HS_START_LOW: begin
                    cnt_ff <= cnt_ff - 3'h1;
                    if (cnt_ff == 3'h0) begin
                        state_ff <= HS_START_HIGH;
                    end
                end
                HS_START_HIGH: begin
                    state_ff <= HS_FRAMES;
                    phase_ff <= PH_TURN;
                    frame_ff <= 5'h00;
                end
                HS_FRAMES: begin
                    phase_ff <= (phase_ff == PH_TURN) ? PH_SAMP :
                                phase_ff + 2'h1;
                    if (phase_ff == PH_TURN) begin
                        frame_ff <= frame_ff + 5'h01;
                    end
                    if (phase_ff == PH_TURN && frame_ff == FRAME_LAST) begin
                        state_ff <= HS_STOP_LOW;
                        cnt_ff   <= quietReq_ff ? {1'b0, STOP_LOW_QUIET} :
                                                  {1'b0, STOP_LOW_CONT};
                        mode_ff  <= quietReq_ff ? SIRQ_QUIET : SIRQ_CONT;
                    end
                end
                HS_STOP_LOW: begin
                    cnt_ff <= cnt_ff - 3'h1;
                    if (cnt_ff <= 3'h1) begin
                        state_ff <= HS_STOP_HIGH;
                    end
                end
                HS_STOP_HIGH: begin
                    state_ff <= HS_IDLE;
                    gapOk_ff <= 1'b0;
                end
                default: begin
                    state_ff <= HS_IDLE;
                end
            endcase
        end
    end

    // levels held until sampled
    // One capture flop per IRQ, loaded in its sample clock
    for (genvar i = 1; i < 16; i++) begin : g_rx
        always_ff @(posedge clk_sys) begin
            if (reset) begin
                rx_ff[i] <= 1'b1;
            end else if (state_ff == HS_FRAMES && phase_ff == PH_SAMP &&
                         frame_ff == 5'(i + 1)) begin
                rx_ff[i] <= link.lineLevel;
            end
        end
    end

    assign link.hostDriveEn  = ~reset & ((state_ff == HS_START_LOW) |
                               (state_ff == HS_START_HIGH) |
                               (state_ff == HS_STOP_LOW) |
                               (state_ff == HS_STOP_HIGH));
    assign link.hostDriveVal = (state_ff == HS_START_HIGH) |
                               (state_ff == HS_STOP_HIGH);

endmodule : sirq_host

// *** sirq_assertions.sv ***
// Purpose: Concurrent checks on the serial IRQ line between both ends.
// Assumes: One clock; reset synchronous, active high.
// Notes:   Takes the interface signals as plain inputs; no bind.
`timescale 1ns/1ps
module sirq_assertions (
    // System
    input wire logic clk_sys,
    input wire logic reset,
    // Line drivers and resolved level
    input wire logic devDriveEn,
    input wire logic devDriveVal,
    input wire logic hostDriveEn,
    input wire logic hostDriveVal,
    input wire logic lineLevel
);
    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic hostSeen_ff;

    // Host has driven since reset; device may not start before that
    always_ff @(posedge clk_sys) begin
        if (reset)
            hostSeen_ff <= 1'b0;
        else if (hostDriveEn)
            hostSeen_ff <= 1'b1;
    end

    sequence hostHigh;
        hostDriveEn && hostDriveVal;
    endsequence
    // Start pulses are four low clocks or more, stops three at most
    sequence startEnd;
        !lineLevel[*4] ##1 hostHigh;
    endsequence

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    a_reset_quiet: assert property (disable iff (1'b0)
        reset |-> !devDriveEn && !hostDriveEn)
        else $error("line driven during reset");
    a_no_contention: assert property (!(devDriveEn && hostDriveEn))
        else $error("both ends drive the line");
    a_dev_low_next: assert property ((devDriveEn && !devDriveVal) |=>
        (devDriveEn && devDriveVal) ||
        (!devDriveEn && hostDriveEn && !hostDriveVal))
        else $error("device low not followed by high or takeover");
    a_dev_high_rel: assert property ((devDriveEn && devDriveVal) |=>
        !devDriveEn) else $error("device kept driving after recovery");
    a_host_high_rel: assert property (hostHigh |=> !hostDriveEn)
        else $error("host kept driving after high clock");
    a_host_low_run: assert property (
        $rose(hostDriveEn && !hostDriveVal) |->
        (hostDriveEn && !hostDriveVal)[*2] ##[1:7] hostHigh)
        else $error("host low run out of range");
    a_frame_one_idle: assert property (startEnd |=> !devDriveEn[*4])
        else $error("device drove before frame two");
    a_cont_after_rst: assert property (devDriveEn |-> hostSeen_ff)
        else $error("device started before host cycle");
endmodule : sirq_assertions

// *** serial_irq_slave_with_irq_forcing_bench.sv ***
// Purpose: Self-checking bench joining host and device ends.
// Assumes: APB master tasks; levels read back through the host.
// Notes:   Random IRQ levels and forcing from a fixed seed.
`timescale 1ns/1ps
module serial_irq_slave_with_irq_forcing_bench;
    import sirq_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic [15:1] irqLevel;
    logic        hostSel = 1'b0;
    logic        devSel  = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = '0;
    logic [31:0] pwdata  = '0;
    logic [31:0] hRd, dRd, rd;
    logic        hRdy, dRdy, hErr, dErr, err, fwdEn;
    logic [7:0]  fLo, fHi;
    logic [15:1] expLvl;
    int          miscompares = 0, samplesChecked = 0, cycles = 0;
    int          seed = 99;

    sirq_if link ();
    sirq_host u_sirq_host (.clk_sys(clk_sys), .reset(reset),
        .psel(hostSel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(hRd), .pready(hRdy), .pslverr(hErr),
        .link(link.host));
    sirq_slave u_sirq_slave (.clk_sys(clk_sys), .reset(reset),
        .irqLevel(irqLevel), .psel(devSel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(dRd),
        .pready(dRdy), .pslverr(dErr), .link(link.dev));
    sirq_assertions u_sirq_assertions (.clk_sys(clk_sys), .reset(reset),
        .devDriveEn(link.devDriveEn), .devDriveVal(link.devDriveVal),
        .hostDriveEn(link.hostDriveEn), .hostDriveVal(link.hostDriveVal),
        .lineLevel(link.lineLevel));

    // Clock and a hang guard sized well above the longest sequence
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            final_report();
        end
    end

    // One APB transfer; dev selects the device end
    task automatic apb(input logic dev, input logic wr,
                       input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        hostSel <= ~dev;
        devSel  <= dev;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((dev ? dRdy : hRdy) !== 1'b1 && n < 50);
        rd = dev ? dRd : hRd;
        err = dev ? dErr : hErr;
        if ((dev ? dRdy : hRdy) !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED %0t no pready", $time);
        end
        hostSel <= 1'b0;
        devSel  <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // read after cycle
    // Busy may lag the request, so give the cycle a few clocks first
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (4) @(posedge clk_sys);
        do begin
            apb(1'b0, 1'b0, HOST_ADDR_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
        if (rd[0] !== 1'b0) begin
            miscompares++;
            $display("CHECK FAILED %0t host stays busy", $time);
        end
    endtask : wait_idle

    function automatic logic [15:1] eff(input logic [15:1] l);
        return fwdEn ? l & {fHi, fLo[7:1]} : l;
    endfunction : eff

    function automatic logic [31:0] ctl(input logic [2:0] x, input logic q);
        return {25'h0, x, 1'b0, q, 2'b01};
    endfunction : ctl

    task automatic chk_levels(input logic [15:1] e);
        apb(1'b0, 1'b0, HOST_ADDR_LEVELS, 32'h0);
        chk({17'h0, rd[15:1]}, {17'h0, e});
    endtask : chk_levels

    task automatic final_report();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        irqLevel = 15'($random(seed));
        fLo = 8'hFF;
        fHi = 8'hFF;
        fwdEn = 1'b0;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        wait_idle();
        chk_levels(eff(irqLevel));
        apb(1'b1, 1'b0, DEV_ADDR_FORCE_LO, 32'h0);
        chk(rd, 32'hFF);
        apb(1'b1, 1'b0, DEV_ADDR_CFG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 12; i++) begin
            fLo = (i == 0) ? 8'h00 : 8'($random(seed));
            fHi = (i == 1) ? 8'h00 : 8'($random(seed));
            fwdEn = (i < 2) ? 1'b1 : 1'($random(seed));
            irqLevel <= 15'($random(seed));
            apb(1'b1, 1'b1, DEV_ADDR_FORCE_LO, {24'h0, fLo});
            apb(1'b1, 1'b1, DEV_ADDR_FORCE_HI, {24'h0, fHi});
            apb(1'b1, 1'b1, DEV_ADDR_CFG, {31'h0, fwdEn});
            apb(1'b1, 1'b0, DEV_ADDR_FORCE_HI, 32'h0);
            chk(rd, {24'h0, fHi});
            apb(1'b0, 1'b1, HOST_ADDR_CTRL, ctl(3'(3 + i % 5), 1'b0));
            wait_idle();
            chk_levels(eff(irqLevel));
        end
        // Two-clock stop hands the device the right to start
        apb(1'b0, 1'b1, HOST_ADDR_CTRL, ctl(3'h5, 1'b1));
        wait_idle();
        chk(rd, 32'h2);
        apb(1'b1, 1'b0, DEV_ADDR_STATUS, 32'h0);
        chk(rd, {14'h0, 1'b1, 1'b0, eff(irqLevel), 1'b0});
        irqLevel <= ~irqLevel;
        wait_idle();
        chk_levels(eff(irqLevel));
        // Three-clock stop: a later change must wait for the host
        apb(1'b0, 1'b1, HOST_ADDR_CTRL, ctl(3'h1, 1'b0));
        wait_idle();
        expLvl = eff(irqLevel);
        irqLevel <= ~irqLevel;
        repeat (150) @(posedge clk_sys);
        chk_levels(expLvl);
        apb(1'b0, 1'b0, HOST_ADDR_CTRL, 32'h0);
        chk(rd, {25'h0, START_EXT_MIN, 4'h0});
        final_report();
    end
endmodule : serial_irq_slave_with_irq_forcing_bench
